//--- ovf_delay_timer.sv
// Per-phase definite delay timer counting millisecond ticks
`timescale 1ns/1ps
`default_nettype none
module ovf_delay_timer (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Control
  input  wire logic                       run,
  input  wire logic                       tick,
  input  wire logic [ovf_pkg::DELAY_W-1:0] delay,
  // Expiry
  output logic                            expired
);
  typedef struct packed {
    logic [ovf_pkg::DELAY_W-1:0] cnt;
    logic                        expired;
  } ovf_tmr_state_t;

  ovf_tmr_state_t q, d;

  always_comb begin
    d = q;
    if (!run) begin
      d.cnt = '0;
    end else if (tick && q.cnt < delay) begin
      d.cnt = q.cnt + 16'h0001;
    end
    d.expired = run && d.cnt >= delay;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;

  restart_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    !run |=> q.cnt == '0 && !expired)
    else $error("timer did not restart from zero");
  no_early_a: assert property (@(posedge clk) disable iff (!nrst)
    expired |-> q.cnt >= $past(delay))
    else $error("delay expired early");

endmodule : ovf_delay_timer
`default_nettype wire

//--- ovf_level_detect.sv
// Per-phase overvoltage start detector with drop-off hysteresis
`timescale 1ns/1ps
`default_nettype none
module ovf_level_detect (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Measurement and thresholds
  input  wire logic                     enable,
  input  wire logic [ovf_pkg::RMS_W-1:0] rms_value,
  input  wire logic [ovf_pkg::RMS_W-1:0] pick_thr,
  input  wire logic [ovf_pkg::RMS_W-1:0] drop_thr,
  // Start flag
  output logic                          start
);
  typedef struct packed {
    logic start;
  } ovf_det_state_t;

  ovf_det_state_t q, d;

  always_comb begin
    d = q;
    if (!enable) begin
      d.start = 1'b0;
    end else if (!q.start && rms_value > pick_thr) begin
      d.start = 1'b1;
    end else if (q.start && rms_value <= drop_thr) begin
      d.start = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign start = q.start;

  start_rise_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(start) |-> $past(enable) && $past(rms_value > pick_thr))
    else $error("start rose without overvoltage");
  drop_hyst_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(start) && $past(enable) |-> $past(rms_value <= drop_thr))
    else $error("start fell above drop-off level");

endmodule : ovf_level_detect
`default_nettype wire

//--- ovf_pkg.sv
// Constants and register map of the three-phase definite-time overvoltage block
package ovf_pkg;

  // Clock and timer base
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned DELAY_UNIT_MS = 1;
  localparam int unsigned MS_CYCLES   = CLK_HZ / 1000 * DELAY_UNIT_MS;

  // Widths
  localparam int RMS_W   = 16;
  localparam int LEVEL_W = 8;
  localparam int RATIO_W = 4;
  localparam int DELAY_W = 16;
  localparam int TICK_W  = 16;
  localparam int ADDR_W  = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF   = 8'h00;
  localparam logic [ADDR_W-1:0] LEVEL_OFF  = 8'h04;
  localparam logic [ADDR_W-1:0] RATIO_OFF  = 8'h08;
  localparam logic [ADDR_W-1:0] DELAY_OFF  = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h10;

  // Control fields
  localparam int CTRL_OPER_BIT  = 0;
  localparam int CTRL_STONLY_BIT = 1;
  localparam int CTRL_PTP_BIT   = 2;

  // Status fields
  localparam int ST_START_LSB = 0;
  localparam int ST_GEN_START = 3;
  localparam int ST_GEN_TRIP  = 4;
  localparam int ST_TRIP_LSB  = 5;
  localparam int ST_BLOCK     = 8;
  localparam int ST_PTP       = 9;

  // Setting ranges and defaults
  localparam logic [LEVEL_W-1:0] LEVEL_MIN = 8'h1e;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'h82;
  localparam logic [LEVEL_W-1:0] LEVEL_DEF = 8'h6e;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 4'h1;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 4'ha;
  localparam logic [RATIO_W-1:0] RATIO_DEF = 4'h5;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 16'hea60;
  localparam logic [DELAY_W-1:0] DELAY_DEF = 16'h0064;
  localparam logic               STONLY_DEF = 1'b0;
  localparam logic               PTP_DEF   = 1'b1;

  // Magnitude scale: one rms unit is 0.01 % of nominal
  localparam logic [RMS_W-1:0] RMS_PER_PCT = 16'h0064;
  localparam logic [RMS_W-1:0] PCT_FULL    = 16'h0064;

  typedef enum logic {
    OVF_OP_OFF = 1'b0,
    OVF_OP_ON  = 1'b1
  } ovf_oper_t;

endpackage : ovf_pkg

//--- ovf_src_model.sv
// Upstream magnitude source model feeding the overvoltage block
`timescale 1ns/1ps
`default_nettype none
module ovf_src_model (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Requested magnitudes
  input  wire logic [ovf_pkg::RMS_W-1:0] want_a,
  input  wire logic [ovf_pkg::RMS_W-1:0] want_b,
  input  wire logic [ovf_pkg::RMS_W-1:0] want_c,
  // Delivered magnitudes
  output logic      [ovf_pkg::RMS_W-1:0] rms_a,
  output logic      [ovf_pkg::RMS_W-1:0] rms_b,
  output logic      [ovf_pkg::RMS_W-1:0] rms_c
);
  // A fresh fundamental magnitude each cycle; pair values arrive already formed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rms_a <= '0;
      rms_b <= '0;
      rms_c <= '0;
    end else begin
      rms_a <= want_a;
      rms_b <= want_b;
      rms_c <= want_c;
    end
  end
endmodule : ovf_src_model
`default_nettype wire

//--- ovf_top.sv
// Three-phase definite-time overvoltage decision block with APB settings
`timescale 1ns/1ps
`default_nettype none
module ovf_top #(
  parameter int unsigned TICK_CYCLES = ovf_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ovf_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Measured magnitudes
  input  wire logic [ovf_pkg::RMS_W-1:0]   phase_a_rms,
  input  wire logic [ovf_pkg::RMS_W-1:0]   phase_b_rms,
  input  wire logic [ovf_pkg::RMS_W-1:0]   phase_c_rms,
  // Blocking
  input  wire logic                        block_input,
  // Decision outputs
  output logic                             phase_a_start,
  output logic                             phase_b_start,
  output logic                             phase_c_start,
  output logic                             general_start,
  output logic                             general_trip,
  output logic                             phase_to_phase_mode
);

  typedef struct packed {
    ovf_pkg::ovf_oper_t                 oper;
    logic                               stonly;
    logic                               ptp;
    logic [ovf_pkg::LEVEL_W-1:0]        level;
    logic [ovf_pkg::RATIO_W-1:0]        ratio;
    logic [ovf_pkg::DELAY_W-1:0]        delay;
    logic [ovf_pkg::TICK_W-1:0]         tick_cnt;
    logic                               tick;
    logic                               gen_start;
    logic                               gen_trip;
    logic [31:0]                        rdata;
    logic                               err;
  } ovf_top_state_t;

  localparam ovf_top_state_t RST = '{
    oper:      ovf_pkg::OVF_OP_OFF,
    stonly:    ovf_pkg::STONLY_DEF,
    ptp:       ovf_pkg::PTP_DEF,
    level:     ovf_pkg::LEVEL_DEF,
    ratio:     ovf_pkg::RATIO_DEF,
    delay:     ovf_pkg::DELAY_DEF,
    tick_cnt:  '0,
    tick:      1'b0,
    gen_start: 1'b0,
    gen_trip:  1'b0,
    rdata:     '0,
    err:       1'b0
  };

  ovf_top_state_t q, d;

  logic                        fn_en;
  logic [2:0]                  starts;
  logic [2:0]                  trips;
  logic [ovf_pkg::RMS_W-1:0]   pick_thr;
  logic [ovf_pkg::RMS_W-1:0]   drop_thr;
  logic                        setup;
  logic                        access;
  logic [31:0]                 ctrl_word;
  logic [31:0]                 status_word;
  logic                        phase_a_trip_internal;
  logic                        phase_b_trip_internal;
  logic                        phase_c_trip_internal;

  // Function runs only when switched on and not blocked
  assign fn_en = (q.oper == ovf_pkg::OVF_OP_ON) && !block_input;

  // Thresholds in rms units
  assign pick_thr = 16'(16'(q.level) * ovf_pkg::RMS_PER_PCT);
  assign drop_thr = 16'(16'(q.level) * 16'(ovf_pkg::PCT_FULL - 16'(q.ratio)));

  ovf_level_detect u_det_a (
    .clk       (clk),
    .nrst      (nrst),
    .enable    (fn_en),
    .rms_value (phase_a_rms),
    .pick_thr  (pick_thr),
    .drop_thr  (drop_thr),
    .start     (starts[0])
  );

  ovf_level_detect u_det_b (
    .clk       (clk),
    .nrst      (nrst),
    .enable    (fn_en),
    .rms_value (phase_b_rms),
    .pick_thr  (pick_thr),
    .drop_thr  (drop_thr),
    .start     (starts[1])
  );

  ovf_level_detect u_det_c (
    .clk       (clk),
    .nrst      (nrst),
    .enable    (fn_en),
    .rms_value (phase_c_rms),
    .pick_thr  (pick_thr),
    .drop_thr  (drop_thr),
    .start     (starts[2])
  );

  // Timers run only while the phase stays started
  ovf_delay_timer u_tmr_a (
    .clk     (clk),
    .nrst    (nrst),
    .run     (starts[0] && fn_en),
    .tick    (q.tick),
    .delay   (q.delay),
    .expired (phase_a_trip_internal)
  );

  ovf_delay_timer u_tmr_b (
    .clk     (clk),
    .nrst    (nrst),
    .run     (starts[1] && fn_en),
    .tick    (q.tick),
    .delay   (q.delay),
    .expired (phase_b_trip_internal)
  );

  ovf_delay_timer u_tmr_c (
    .clk     (clk),
    .nrst    (nrst),
    .run     (starts[2] && fn_en),
    .tick    (q.tick),
    .delay   (q.delay),
    .expired (phase_c_trip_internal)
  );

  // Phase trips get no output port; they leave only as status bits and through the general trip
  assign trips = {phase_c_trip_internal, phase_b_trip_internal, phase_a_trip_internal};

  assign setup  = psel && !penable;
  assign access = psel && penable;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[ovf_pkg::CTRL_OPER_BIT]   = q.oper;
    ctrl_word[ovf_pkg::CTRL_STONLY_BIT] = q.stonly;
    ctrl_word[ovf_pkg::CTRL_PTP_BIT]    = q.ptp;
  end

  always_comb begin
    status_word = '0;
    status_word[ovf_pkg::ST_START_LSB +: 3] = starts;
    status_word[ovf_pkg::ST_GEN_START]      = q.gen_start;
    status_word[ovf_pkg::ST_GEN_TRIP]       = q.gen_trip;
    status_word[ovf_pkg::ST_TRIP_LSB +: 3]  = trips;
    status_word[ovf_pkg::ST_BLOCK]          = block_input;
    status_word[ovf_pkg::ST_PTP]            = q.ptp;
  end

  always_comb begin
    d = q;

    // Millisecond tick divider
    d.tick = 1'b0;
    if (q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      d.tick_cnt = '0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 16'h0001;
    end

    // General outputs
    d.gen_start = fn_en && (|starts);
    d.gen_trip  = fn_en && !q.stonly && (|trips);

    // Read data and error are settled in the setup cycle
    if (setup) begin
      d.rdata = '0;
      d.err   = 1'b0;
      case (paddr)
        ovf_pkg::CTRL_OFF: begin
          d.rdata = ctrl_word;
        end
        ovf_pkg::LEVEL_OFF: begin
          d.rdata = 32'(q.level);
          if (pwrite && (pwdata[ovf_pkg::LEVEL_W-1:0] < ovf_pkg::LEVEL_MIN ||
                         pwdata[ovf_pkg::LEVEL_W-1:0] > ovf_pkg::LEVEL_MAX)) begin
            d.err = 1'b1;
          end
        end
        ovf_pkg::RATIO_OFF: begin
          d.rdata = 32'(q.ratio);
          if (pwrite && (pwdata[ovf_pkg::RATIO_W-1:0] < ovf_pkg::RATIO_MIN ||
                         pwdata[ovf_pkg::RATIO_W-1:0] > ovf_pkg::RATIO_MAX)) begin
            d.err = 1'b1;
          end
        end
        ovf_pkg::DELAY_OFF: begin
          d.rdata = 32'(q.delay);
          if (pwrite && pwdata[ovf_pkg::DELAY_W-1:0] > ovf_pkg::DELAY_MAX) begin
            d.err = 1'b1;
          end
        end
        ovf_pkg::STATUS_OFF: begin
          d.rdata = status_word;
          if (pwrite) begin
            d.err = 1'b1;
          end
        end
        default: begin
          d.err = 1'b1;
        end
      endcase
    end

    // Writes take effect at the access edge unless refused
    if (access && pwrite && !q.err) begin
      case (paddr)
        ovf_pkg::CTRL_OFF: begin
          d.oper   = ovf_pkg::ovf_oper_t'(pwdata[ovf_pkg::CTRL_OPER_BIT]);
          d.stonly = pwdata[ovf_pkg::CTRL_STONLY_BIT];
          d.ptp    = pwdata[ovf_pkg::CTRL_PTP_BIT];
        end
        ovf_pkg::LEVEL_OFF: begin
          d.level = pwdata[ovf_pkg::LEVEL_W-1:0];
        end
        ovf_pkg::RATIO_OFF: begin
          d.ratio = pwdata[ovf_pkg::RATIO_W-1:0];
        end
        ovf_pkg::DELAY_OFF: begin
          d.delay = pwdata[ovf_pkg::DELAY_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Zero-wait-state slave
  assign pready  = 1'b1;
  assign prdata  = q.rdata;
  assign pslverr = access && q.err;

  assign phase_a_start       = starts[0];
  assign phase_b_start       = starts[1];
  assign phase_c_start       = starts[2];
  assign general_start       = q.gen_start;
  assign general_trip        = q.gen_trip;
  // Tells the upstream stage which magnitudes to deliver
  assign phase_to_phase_mode = q.ptp;

  gen_start_or_a: assert property (@(posedge clk) disable iff (!nrst)
    general_start == $past(fn_en && (|starts)))
    else $error("general start is not the OR of phase starts");

  gen_trip_a: assert property (@(posedge clk) disable iff (!nrst)
    general_trip |-> $past(|trips) && !$past(q.stonly))
    else $error("general trip without expired phase");

  trip_follows_a: assert property (@(posedge clk) disable iff (!nrst)
    fn_en && !q.stonly && (|trips) |=> general_trip)
    else $error("expired delay did not trip");

  off_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    (q.oper == ovf_pkg::OVF_OP_OFF) ##1 (q.oper == ovf_pkg::OVF_OP_OFF)
    |=> !general_start && !general_trip && !phase_a_start)
    else $error("outputs active while switched off");

  block_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    block_input ##1 block_input |=> !general_start && !general_trip && (starts == 3'b000))
    else $error("outputs active while blocked");

  start_only_a: assert property (@(posedge clk) disable iff (!nrst)
    q.stonly && $past(q.stonly) |-> !general_trip)
    else $error("trip in start-only mode");

  level_range_a: assert property (@(posedge clk) disable iff (!nrst)
    access && pwrite && paddr == ovf_pkg::LEVEL_OFF &&
    pwdata[ovf_pkg::LEVEL_W-1:0] > ovf_pkg::LEVEL_MAX |=> q.level == $past(q.level))
    else $error("out-of-range level accepted");

  delay_range_a: assert property (@(posedge clk) disable iff (!nrst)
    access && pwrite && paddr == ovf_pkg::DELAY_OFF && !pslverr
    |=> q.delay == $past(pwdata[ovf_pkg::DELAY_W-1:0]) && q.delay <= ovf_pkg::DELAY_MAX)
    else $error("delay write not stored");

  tick_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    q.tick |=> !q.tick)
    else $error("millisecond tick too frequent");

  ratio_range_a: assert property (@(posedge clk) disable iff (!nrst)
    access && pwrite && paddr == ovf_pkg::RATIO_OFF && (pwdata[ovf_pkg::RATIO_W-1:0] < ovf_pkg::RATIO_MIN ||
    pwdata[ovf_pkg::RATIO_W-1:0] > ovf_pkg::RATIO_MAX) |=> q.ratio == $past(q.ratio))
    else $error("out-of-range ratio accepted");

  level_store_a: assert property (@(posedge clk) disable iff (!nrst)
    access && pwrite && paddr == ovf_pkg::LEVEL_OFF && !pslverr
    |=> q.level == $past(pwdata[ovf_pkg::LEVEL_W-1:0]))
    else $error("level write not stored");

  trip_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(starts[0]) |=> !phase_a_trip_internal)
    else $error("phase delay kept running after drop-off");

  start_enable_a: assert property (@(posedge clk) disable iff (!nrst)
    !fn_en |=> starts == 3'b000)
    else $error("start while function disabled");

endmodule : ovf_top
`default_nettype wire

//--- ovf_top_bench.sv
// Self-checking testbench of the overvoltage decision block
`timescale 1ns/1ps
`default_nettype none
module ovf_top_bench;
  localparam int TC = 4;
  localparam int DL = 5;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] want_a = 16'h0;
  logic [15:0] want_b = 16'h0;
  logic [15:0] want_c = 16'h0;
  logic [15:0] rms_a, rms_b, rms_c;
  logic        block_input = 1'b0;
  logic        pa, pb, pc, gs, gt, ptp;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  logic [31:0] rnd = 32'hd817952f;
  logic [2:0]  h;
  logic [15:0] v [3];
  logic [7:0]  ta [12] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h14};
  logic [31:0] tv [12] = '{29, 131, 30, 130, 0, 11, 10, 1, 60001, 60000, 0, 1};
  logic        te [12] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  always #12.5 clk = ~clk;

  ovf_src_model ovf_src_model_i (.clk(clk), .nrst(nrst), .want_a(want_a), .want_b(want_b), .want_c(want_c),
    .rms_a(rms_a), .rms_b(rms_b), .rms_c(rms_c));
  ovf_top #(.TICK_CYCLES(TC)) ovf_top_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_rms(rms_a), .phase_b_rms(rms_b), .phase_c_rms(rms_c), .block_input(block_input),
    .phase_a_start(pa), .phase_b_start(pb), .phase_c_start(pc), .general_start(gs), .general_trip(gt),
    .phase_to_phase_mode(ptp));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; for reads d is the expected data
  task automatic apb(input string what, input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    logic        ok, e;
    logic [31:0] got;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that sees pready high
    do begin
      @(posedge clk);
      ok  = pready;
      got = prdata;
      e   = pslverr;
    end while (ok !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    check({what, "_err"}, {31'h0, e}, {31'h0, err});
    if (!wr) begin
      check(what, got, d);
    end
  endtask : apb

  task automatic set3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    want_a <= a;
    want_b <= b;
    want_c <= c;
  endtask : set3

  task automatic wait_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wait_n

  // Cycles from phase a start to general trip
  task automatic trip_time(input logic [15:0] a);
    set3(a, 16'h0, 16'h0);
    n = 0;
    wait_n(1);
    while (pa !== 1'b1 && n < 10) begin
      wait_n(1);
      n++;
    end
    n = 0;
    while (gt !== 1'b1 && n < 100 * TC) begin
      wait_n(1);
      n++;
    end
    check("trip_time", 32'(n >= (DL - 1) * TC && n <= DL * TC + 3), 32'h1);
  endtask : trip_time

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    wait_n(1);
    check("ptp_mode", 32'(ptp), 32'h1);
    apb("ctrl_def", 0, ovf_pkg::CTRL_OFF, 32'h4, 0);
    apb("level_def", 0, ovf_pkg::LEVEL_OFF, 32'h6e, 0);
    apb("ratio_def", 0, ovf_pkg::RATIO_OFF, 32'h5, 0);
    apb("delay_def", 0, ovf_pkg::DELAY_OFF, 32'h64, 0);
    set3(16'hffff, 16'hffff, 16'hffff);
    wait_n(4 * TC);
    check("off_outputs", 32'({pa, pb, pc, gs, gt}), 32'h0);
    $display("test defaults done");
    for (int i = 0; i < 12; i++) begin
      apb("setting_write", 1, ta[i], tv[i], te[i]);
    end
    apb("unmapped_rd", 0, 8'h14, 32'h0, 1);
    apb("level_rd", 0, ovf_pkg::LEVEL_OFF, 32'h82, 0);
    apb("ratio_rd", 0, ovf_pkg::RATIO_OFF, 32'h1, 0);
    apb("delay_rd", 0, ovf_pkg::DELAY_OFF, 32'hea60, 0);
    $display("test settings done");
    apb("level_wr", 1, ovf_pkg::LEVEL_OFF, 32'h64, 0);
    apb("ratio_wr", 1, ovf_pkg::RATIO_OFF, 32'h5, 0);
    apb("delay_wr", 1, ovf_pkg::DELAY_OFF, DL, 0);
    set3(16'd10000, 16'h0, 16'h0);
    apb("ctrl_on", 1, ovf_pkg::CTRL_OFF, 32'h5, 0);
    wait_n(3);
    check("at_level", 32'({pa, pb, pc, gs}), 32'h0);
    set3(16'd10001, 16'h0, 16'h0);
    wait_n(3);
    check("above_level", 32'({pa, pb, pc, gs}), 32'h9);
    set3(16'd9501, 16'h0, 16'h0);
    wait_n(3);
    check("in_band", 32'({pa, gs}), 32'h3);
    set3(16'd9500, 16'h0, 16'h0);
    wait_n(3);
    check("dropped", 32'({pa, gs, gt}), 32'h0);
    $display("test hysteresis done");
    trip_time(16'd10001 + {4'h0, rnd[11:0]});
    apb("status", 0, ovf_pkg::STATUS_OFF, 32'h239, 0);
    set3(16'h0, 16'h0, 16'h0);
    wait_n(4);
    check("trip_clear", 32'({pa, gs, gt}), 32'h0);
    set3(16'hffff, 16'h0, 16'h0);
    wait_n(2 + DL * TC / 2);
    check("no_early_trip", 32'(gt), 32'h0);
    set3(16'h0, 16'h0, 16'h0);
    wait_n(4);
    trip_time(16'hffff);
    set3(16'h0, 16'h0, 16'h0);
    $display("test delay done");
    apb("ctrl_stonly", 1, ovf_pkg::CTRL_OFF, 32'h3, 0);
    set3(16'd20000, 16'h0, 16'h0);
    wait_n(DL * TC + 10);
    check("start_only", 32'({gs, gt, ptp}), 32'h4);
    apb("ctrl_on2", 1, ovf_pkg::CTRL_OFF, 32'h5, 0);
    @(posedge clk);
    block_input <= 1'b1;
    wait_n(DL * TC + 10);
    check("blocked", 32'({pa, gs, gt}), 32'h0);
    @(posedge clk);
    block_input <= 1'b0;
    $display("test modes done");
    apb("delay_long", 1, ovf_pkg::DELAY_OFF, 32'hea60, 0);
    for (int k = 0; k < 16; k++) begin
      for (int p = 0; p < 3; p++) begin
        rnd = lfsr(rnd);
        h[p] = rnd[31];
        v[p] = h[p] ? 16'd10001 + {3'h0, rnd[12:0]} : 16'(rnd[13:0] % 9501);
      end
      set3(v[0], v[1], v[2]);
      wait_n(3);
      check("random_starts", 32'({pa, pb, pc, gs}), 32'({h[0], h[1], h[2], |h}));
    end
    $display("test random done");
    final_report();
  end
endmodule : ovf_top_bench
`default_nettype wire
